// ===== verilog/prt_pkg.sv
`default_nettype none
package prt_pkg;
	localparam int CW = 10;
	// ****************************************
	// register byte addresses
	// ****************************************
	localparam logic [7:0] ADDR_CTRL0 = 8'h00;
	localparam logic [7:0] ADDR_CTRL1 = 8'h04;
	localparam logic [7:0] ADDR_CNT_LO = 8'h08;
	localparam logic [7:0] ADDR_CNT_HI = 8'h0C;
	localparam logic [7:0] ADDR_CMPA_LO = 8'h10;
	localparam logic [7:0] ADDR_CMPA_HI = 8'h14;
	localparam logic [7:0] ADDR_PER_LO = 8'h18;
	localparam logic [7:0] ADDR_PER_HI = 8'h1C;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
	localparam logic [7:0] ADDR_IRQ_CLR = 8'h24;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h28;
	// ****************************************
	// field positions and reset values
	// ****************************************
	localparam int C0_PAUSE = 7;
	localparam int C0_CKSEL = 4;
	localparam int C0_RUN = 3;
	localparam int C1_MODE = 6;
	localparam int C1_FUNC = 4;
	localparam int C1_INIT = 3;
	localparam int C1_INV = 2;
	localparam int C1_RSVD = 1;
	localparam int C1_CLRSEL = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [CW-1:0] CMP_RESET = 10'h000;
	localparam logic [CW-1:0] CNT_MAX = 10'h3FF;
	localparam int IRQ_A = 0;
	localparam int IRQ_P = 1;
	// ****************************************
	// prescaler divides
	// ****************************************
	localparam logic [5:0] DIV4_LAST = 6'h03;
	localparam logic [5:0] DIV16_LAST = 6'h0F;
	localparam logic [5:0] DIV64_LAST = 6'h3F;
	// ****************************************
	// encodings
	// ****************************************
	typedef enum logic [1:0] {
		MODE_CMP = 2'b00,
		MODE_UNDEF = 2'b01,
		MODE_PWM = 2'b10,
		MODE_TMR = 2'b11
	} prt_mode_t;
	typedef enum logic [1:0] {
		FN_NONE = 2'b00,
		FN_LOW = 2'b01,
		FN_HIGH = 2'b10,
		FN_TOGGLE = 2'b11
	} prt_func_t;
	typedef enum logic [2:0] {
		CK_SYS4 = 3'b000,
		CK_SYS = 3'b001,
		CK_H16 = 3'b010,
		CK_H64 = 3'b011,
		CK_SUB0 = 3'b100,
		CK_SUB1 = 3'b101,
		CK_PIN_RISE = 3'b110,
		CK_PIN_FALL = 3'b111
	} prt_clk_t;
endpackage
`default_nettype wire

// ===== verilog/prt_cmp.sv
`timescale 1ns/10ps
`default_nettype none
module prt_cmp
	import prt_pkg::*;
#(
	parameter int W = 10
) (
	// compare inputs
	input wire logic [W-1:0] value,
	input wire logic [W-1:0] count,
	// result
	output logic hit
);
	// ****************************************
	// full-width equality against all counter bits
	// ****************************************
	assign hit = (value == count);
endmodule
`default_nettype wire

// ===== verilog/prt_clk_sel.sv
`timescale 1ns/10ps
`default_nettype none
module prt_clk_sel
	import prt_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// sources
	input wire logic [2:0] sel,
	input wire logic sub_clock_tick,
	input wire logic external_clock_pin,
	// timer clock enable
	output logic tick
);
	logic [5:0] div_q;
	logic sync1_q;
	logic sync2_q;
	logic prev_q;
	// ****************************************
	// prescaler and pin synchroniser
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_q <= 6'h00;
		end else begin
			div_q <= div_q + 6'h01;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			sync1_q <= external_clock_pin;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end
	// ****************************************
	// source select
	// ****************************************
	always_comb begin
		case (prt_clk_t'(sel))
			CK_SYS4: tick = (div_q[1:0] == DIV4_LAST[1:0]);
			CK_SYS: tick = 1'b1;
			CK_H16: tick = (div_q[3:0] == DIV16_LAST[3:0]);
			CK_H64: tick = (div_q == DIV64_LAST);
			CK_SUB0, CK_SUB1: tick = sub_clock_tick;
			CK_PIN_RISE: tick = sync2_q & ~prev_q;
			default: tick = ~sync2_q & prev_q;
		endcase
	end
endmodule
`default_nettype wire

// ===== verilog/prt_top.sv
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module prt_top
	import prt_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// clock sources
	input wire logic sub_clock_tick,
	input wire logic external_clock_pin,
	// outputs
	output logic timer_output_pin,
	output logic irq
);
	// ****************************************
	// state
	// ****************************************
	logic count_pause_q;
	logic [2:0] clock_source_select_q;
	logic run_control_q;
	logic run_prev_q;
	logic [1:0] operating_mode_select_q;
	logic [1:0] output_function_select_q;
	logic output_initial_level_q;
	logic output_invert_q;
	logic ctrl1_rsvd_q;
	logic counter_clear_select_q;
	logic [CW-1:0] count_q;
	logic [CW-1:0] compare_a_value_q;
	logic [CW-1:0] period_compare_value_q;
	logic [1:0] irq_stat_q;
	logic [1:0] irq_en_q;
	logic out_state_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic pin_q;
	logic irq_q;
	// ****************************************
	// decode helpers
	// ****************************************
	logic tick;
	logic hit_a;
	logic hit_p;
	logic run_rise;
	logic advance;
	logic wr;
	logic rd;
	logic mapped;
	logic is_pwm;
	logic single_pulse;
	logic ev_a;
	logic ev_p;
	logic clr_cnt;
	logic sp_stop;
	logic pwm_active;
	logic [1:0] irq_set;
	logic [7:0] ctrl0_rd;
	logic [7:0] ctrl1_rd;

	assign wr = psel & penable & pwrite & ~pready_q;
	assign rd = psel & penable & ~pwrite & ~pready_q;
	assign run_rise = run_control_q & ~run_prev_q;
	assign advance = run_control_q & ~run_rise & ~count_pause_q & tick;
	assign is_pwm = (operating_mode_select_q == MODE_PWM);
	assign single_pulse = is_pwm & (output_function_select_q == FN_TOGGLE);

	always_comb begin
		if (paddr == ADDR_CTRL0) begin
			mapped = 1'b1;
		end else if (paddr == ADDR_CTRL1 || paddr == ADDR_CNT_LO) begin
			mapped = 1'b1;
		end else if (paddr == ADDR_CNT_HI || paddr == ADDR_CMPA_LO) begin
			mapped = 1'b1;
		end else if (paddr == ADDR_CMPA_HI || paddr == ADDR_PER_LO) begin
			mapped = 1'b1;
		end else if (paddr == ADDR_PER_HI || paddr == ADDR_IRQ_STAT) begin
			mapped = 1'b1;
		end else if (paddr == ADDR_IRQ_CLR || paddr == ADDR_IRQ_EN) begin
			mapped = 1'b1;
		end else begin
			mapped = 1'b0;
		end
	end

	// ****************************************
	// timer clock and comparators
	// ****************************************
	prt_clk_sel u_clk_sel (
		.clk(clk),
		.rst_n(rst_n),
		.sel(clock_source_select_q),
		.sub_clock_tick(sub_clock_tick),
		.external_clock_pin(external_clock_pin),
		.tick(tick)
	);

	prt_cmp #(.W(CW)) u_cmp_a (
		.value(compare_a_value_q),
		.count(count_q),
		.hit(hit_a)
	);

	prt_cmp #(.W(CW)) u_cmp_p (
		.value(period_compare_value_q),
		.count(count_q),
		.hit(hit_p)
	);

	// ****************************************
	// match events
	// ****************************************
	always_comb begin
		ev_a = 1'b0;
		ev_p = 1'b0;
		clr_cnt = 1'b0;
		sp_stop = 1'b0;
		if (advance) begin
			if (single_pulse) begin
				ev_a = hit_a;
				sp_stop = hit_a;
			end else if (is_pwm) begin
				ev_a = hit_a;
				if (period_compare_value_q == CMP_RESET) begin
					ev_p = (count_q == CNT_MAX);
				end else begin
					ev_p = hit_p;
				end
				clr_cnt = ev_p;
			end else if (counter_clear_select_q) begin
				ev_a = hit_a & (compare_a_value_q != CMP_RESET);
				clr_cnt = ev_a;
			end else begin
				ev_a = hit_a & (compare_a_value_q != CMP_RESET);
				if (period_compare_value_q == CMP_RESET) begin
					ev_p = (count_q == CNT_MAX);
				end else begin
					ev_p = hit_p;
				end
				clr_cnt = ev_p;
			end
		end
	end

	// ****************************************
	// counter
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_q <= CMP_RESET;
		end else if (run_rise) begin
			count_q <= CMP_RESET;
		end else if (clr_cnt) begin
			count_q <= CMP_RESET;
		end else if (sp_stop) begin
			count_q <= count_q;
		end else if (advance) begin
			count_q <= count_q + 10'h001;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			run_prev_q <= 1'b0;
		end else begin
			run_prev_q <= run_control_q;
		end
	end

	// ****************************************
	// control registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_pause_q <= CTRL_RESET[C0_PAUSE];
			clock_source_select_q <= CTRL_RESET[C0_CKSEL +: 3];
			run_control_q <= CTRL_RESET[C0_RUN];
		end else if (wr && paddr == ADDR_CTRL0) begin
			count_pause_q <= pwdata[C0_PAUSE];
			clock_source_select_q <= pwdata[C0_CKSEL +: 3];
			run_control_q <= pwdata[C0_RUN];
		end else if (sp_stop) begin
			run_control_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			operating_mode_select_q <= CTRL_RESET[C1_MODE +: 2];
			output_function_select_q <= CTRL_RESET[C1_FUNC +: 2];
			output_initial_level_q <= CTRL_RESET[C1_INIT];
			output_invert_q <= CTRL_RESET[C1_INV];
			ctrl1_rsvd_q <= CTRL_RESET[C1_RSVD];
			counter_clear_select_q <= CTRL_RESET[C1_CLRSEL];
		end else if (wr && paddr == ADDR_CTRL1) begin
			operating_mode_select_q <= pwdata[C1_MODE +: 2];
			output_function_select_q <= pwdata[C1_FUNC +: 2];
			output_initial_level_q <= pwdata[C1_INIT];
			output_invert_q <= pwdata[C1_INV];
			ctrl1_rsvd_q <= pwdata[C1_RSVD];
			counter_clear_select_q <= pwdata[C1_CLRSEL];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			compare_a_value_q <= CMP_RESET;
			period_compare_value_q <= CMP_RESET;
		end else if (wr) begin
			if (paddr == ADDR_CMPA_LO) begin
				compare_a_value_q[7:0] <= pwdata[7:0];
			end else if (paddr == ADDR_CMPA_HI) begin
				compare_a_value_q[CW-1:8] <= pwdata[CW-9:0];
			end else if (paddr == ADDR_PER_LO) begin
				period_compare_value_q[7:0] <= pwdata[7:0];
			end else if (paddr == ADDR_PER_HI) begin
				period_compare_value_q[CW-1:8] <= pwdata[CW-9:0];
			end
		end
	end

	// ****************************************
	// interrupts
	// ****************************************
	assign irq_set = {ev_p, ev_a};

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_stat_q <= 2'h0;
		end else if (wr && paddr == ADDR_IRQ_CLR) begin
			irq_stat_q <= (irq_stat_q & ~pwdata[1:0]) | irq_set;
		end else begin
			irq_stat_q <= irq_stat_q | irq_set;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_en_q <= 2'h0;
		end else if (wr && paddr == ADDR_IRQ_EN) begin
			irq_en_q <= pwdata[1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irq_stat_q & irq_en_q);
		end
	end

	// ****************************************
	// output pin
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			out_state_q <= 1'b0;
		end else if (run_rise) begin
			out_state_q <= output_initial_level_q;
		end else if (ev_a && !is_pwm) begin
			case (prt_func_t'(output_function_select_q))
				FN_LOW: out_state_q <= 1'b0;
				FN_HIGH: out_state_q <= 1'b1;
				FN_TOGGLE: out_state_q <= ~out_state_q;
				default: out_state_q <= out_state_q;
			endcase
		end
	end

	always_comb begin
		case (prt_func_t'(output_function_select_q))
			FN_NONE: pwm_active = 1'b0;
			FN_LOW: pwm_active = 1'b1;
			FN_HIGH: pwm_active = (count_q < compare_a_value_q);
			default: pwm_active = run_control_q & ~sp_stop;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pin_q <= 1'b0;
		end else if (operating_mode_select_q == MODE_TMR) begin
			pin_q <= 1'b0;
		end else if (is_pwm) begin
			pin_q <= (pwm_active ~^ output_initial_level_q) ^ output_invert_q;
		end else if (run_rise) begin
			pin_q <= output_initial_level_q ^ output_invert_q;
		end else begin
			pin_q <= out_state_q ^ output_invert_q;
		end
	end

	// ****************************************
	// apb read and answer
	// ****************************************
	assign ctrl0_rd = {count_pause_q, clock_source_select_q, run_control_q, 3'h0};
	assign ctrl1_rd = {operating_mode_select_q, output_function_select_q,
		output_initial_level_q, output_invert_q, ctrl1_rsvd_q, counter_clear_select_q};

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prdata_q <= 32'h0000_0000;
		end else if (rd) begin
			if (paddr == ADDR_CTRL0) begin
				prdata_q <= {24'h00_0000, ctrl0_rd};
			end else if (paddr == ADDR_CTRL1) begin
				prdata_q <= {24'h00_0000, ctrl1_rd};
			end else if (paddr == ADDR_CNT_LO) begin
				prdata_q <= {24'h00_0000, count_q[7:0]};
			end else if (paddr == ADDR_CNT_HI) begin
				prdata_q <= {30'h0000_0000, count_q[CW-1:8]};
			end else if (paddr == ADDR_CMPA_LO) begin
				prdata_q <= {24'h00_0000, compare_a_value_q[7:0]};
			end else if (paddr == ADDR_CMPA_HI) begin
				prdata_q <= {30'h0000_0000, compare_a_value_q[CW-1:8]};
			end else if (paddr == ADDR_PER_LO) begin
				prdata_q <= {24'h00_0000, period_compare_value_q[7:0]};
			end else if (paddr == ADDR_PER_HI) begin
				prdata_q <= {30'h0000_0000, period_compare_value_q[CW-1:8]};
			end else if (paddr == ADDR_IRQ_STAT) begin
				prdata_q <= {30'h0000_0000, irq_stat_q};
			end else if (paddr == ADDR_IRQ_EN) begin
				prdata_q <= {30'h0000_0000, irq_en_q};
			end else begin
				prdata_q <= 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= psel & penable & ~pready_q;
			pslverr_q <= psel & penable & ~pready_q & ~mapped;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign timer_output_pin = pin_q;
	assign irq = irq_q;
endmodule
`default_nettype wire

// ===== test/prt_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
module prt_top_sva
	import prt_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// pins
	input wire logic timer_output_pin,
	input wire logic irq
);
	logic acc;
	logic rd;
	logic run_q;
	logic [7:0] c1_q;
	logic [1:0] en_q;
	assign acc = psel && penable && !pready && pwrite;
	assign rd = pready && !pwrite;
	// ****************************************
	// shadow of written control state
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			run_q <= 1'b0;
			c1_q <= 8'h00;
			en_q <= 2'h0;
		end else if (acc) begin
			if (paddr == ADDR_CTRL0) begin
				run_q <= pwdata[C0_RUN];
			end
			if (paddr == ADDR_CTRL1) begin
				c1_q <= pwdata[7:0];
			end
			if (paddr == ADDR_IRQ_EN) begin
				en_q <= pwdata[1:0];
			end
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_access;
		psel && penable && !pready;
	endsequence
	sequence s_run_rise;
		acc && paddr == ADDR_CTRL0 && pwdata[C0_RUN] && !run_q && c1_q[7:6] == 2'b00;
	endsequence
	// ****************************************
	// assertions
	// ****************************************
	a_ready_after_access: assert property (s_access |=> pready)
		else $error("no ready after access");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_unmapped: assert property (pready |-> pslverr == (paddr > ADDR_IRQ_EN || paddr[1:0] != 2'h0))
		else $error("error flag wrong for address");
	a_ctrl0_low_zero: assert property (rd && paddr == ADDR_CTRL0 |-> prdata[2:0] == 3'h0)
		else $error("control 0 low bits not zero");
	a_high_pair_bits: assert property (rd && (paddr == ADDR_CNT_HI || paddr == ADDR_CMPA_HI
		|| paddr == ADDR_PER_HI) |-> prdata[31:2] == 30'h0)
		else $error("high half wider than two bits");
	a_byte_wide: assert property (rd |-> prdata[31:8] == 24'h0)
		else $error("read data wider than a byte");
	a_run_init_level: assert property (s_run_rise |-> ##[1:3]
		timer_output_pin == (c1_q[C1_INIT] ^ c1_q[C1_INV]))
		else $error("pin not at initial level after run");
	a_irq_masked: assert property (en_q == 2'h0 && $past(en_q) == 2'h0 |-> !irq)
		else $error("interrupt while all masked");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error flag without ready");
endmodule
bind prt_top prt_top_sva u_sva (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .timer_output_pin, .irq);
`default_nettype wire

// ===== test/prt_tb.sv
`timescale 1ns/10ps
`default_nettype none
module prt_top_tb
	import prt_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n, psel, penable, pwrite, ext, sub, pready, pslverr, pin, irq, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdat, d;
	int bad_count = 0;
	int cmp_count = 0;
	int seed = 14;
	int cnt, stat, a, p, clra, tog, xpin, on;
	prt_top DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sub_clock_tick(sub), .external_clock_pin(ext), .timer_output_pin(pin), .irq(irq));
	initial begin
		forever #50 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] dv);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= dv;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	// ****************************************
	// reference model
	// ****************************************
	task automatic step;
		int ma, mp;
		ma = (a != 0 && cnt == a);
		mp = !clra && (p != 0 ? cnt == p : cnt == 1023);
		if (mp) stat |= 2;
		if (ma) stat |= 1;
		if (ma && tog) xpin ^= 1;
		cnt = ((clra ? ma : mp) ? 0 : cnt + 1) % 1024;
	endtask
	task automatic pulse(input int k);
		repeat (k) begin
			ext <= 1'b1;
			repeat (4) @(posedge clk);
			ext <= 1'b0;
			repeat (4) @(posedge clk);
			if (on) step();
		end
	endtask
	task automatic look;
		apb(0, ADDR_CNT_LO, 0);
		chk("count low", cnt % 256, rdat);
		apb(0, ADDR_CNT_HI, 0);
		chk("count high", cnt / 256, rdat);
		apb(0, ADDR_IRQ_STAT, 0);
		chk("status", stat, rdat);
	endtask
	task automatic start(input logic [2:0] s, input logic [7:0] c1, input int av, input int pv);
		apb(1, ADDR_CTRL0, {25'h0, s, 4'h0});
		apb(1, ADDR_CMPA_LO, av % 256);
		apb(1, ADDR_CMPA_HI, av / 256);
		apb(1, ADDR_PER_LO, pv % 256);
		apb(1, ADDR_PER_HI, pv / 256);
		apb(1, ADDR_CTRL1, {24'h0, c1});
		apb(1, ADDR_IRQ_CLR, 3);
		apb(1, ADDR_CTRL0, {25'h0, s, 4'h8});
		a = av;
		p = pv;
		clra = c1[0];
		tog = (c1[5:4] == 2'b11);
		xpin = c1[3] ^ c1[2];
		cnt = 0;
		stat = 0;
		on = 1;
	endtask
	task automatic timed(input logic [2:0] s, input int k, input int dv);
		start(s, 8'h01, 0, 0);
		if (dv == 0) begin
			repeat (k) begin
				sub <= 1'b1;
				@(posedge clk);
				sub <= 1'b0;
				repeat (3) @(posedge clk);
			end
		end else begin
			repeat (k * dv - 3) @(posedge clk);
		end
		apb(1, ADDR_CTRL0, {25'h0, s, 4'h0});
		cnt = k;
		look();
	endtask
	task automatic end_sim;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		#4000000;
		bad_count++;
		end_sim();
	end
	initial begin
		{rst_n, psel, penable, pwrite, ext, sub, paddr, pwdata} <= '0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 11; i++) begin
			apb(0, 8'(i * 4), 0);
			if (i != 9) chk("reset value", 0, rdat);
		end
		apb(0, 8'h2C, 0);
		chk("unmapped error", 1, {31'h0, err});
		chk("unmapped data", 0, rdat);
		apb(1, 8'h2C, 1);
		chk("unmapped write error", 1, {31'h0, err});
		repeat (4) begin
			d = $random(seed);
			apb(1, ADDR_CTRL0, d & 32'h77);
			apb(0, ADDR_CTRL0, 0);
			chk("control 0", d & 32'h70, rdat);
			apb(1, ADDR_CTRL1, d & 32'hFD);
			apb(0, ADDR_CTRL1, 0);
			chk("control 1", d & 32'hFD, rdat);
			for (int i = 4; i < 8; i++) begin
				apb(1, 8'(i * 4), d);
				apb(0, 8'(i * 4), 0);
				chk("compare reg", d & (i[0] ? 3 : 255), rdat);
			end
			apb(1, ADDR_CNT_LO, d);
			apb(0, ADDR_CNT_LO, 0);
			chk("count write", 0, rdat);
		end
		$display("end of register test");
		start(CK_PIN_RISE, 8'h31, 2 + ($random(seed) & 7), 0);
		chk("pin", xpin, pin);
		pulse(a + 2);
		look();
		chk("pin", xpin, pin);
		apb(1, ADDR_IRQ_EN, 1);
		chk("irq", 1, irq);
		apb(1, ADDR_IRQ_CLR, 1);
		stat = 0;
		chk("irq", 0, irq);
		$display("end of compare A test");
		start(CK_PIN_FALL, 8'h3D, 4 + ($random(seed) & 7), 0);
		chk("pin", xpin, pin);
		pulse(2);
		look();
		apb(1, ADDR_CTRL0, 32'hF8);
		on = 0;
		pulse(3);
		look();
		apb(1, ADDR_CTRL0, 32'h78);
		on = 1;
		pulse(1);
		look();
		apb(1, ADDR_CTRL0, 32'h70);
		on = 0;
		pulse(2);
		look();
		apb(1, ADDR_CTRL0, 32'h78);
		cnt = 0;
		on = 1;
		look();
		chk("pin", xpin, pin);
		$display("end of run control test");
		start(CK_PIN_RISE, 8'h00, 1, 2 + ($random(seed) & 3));
		pulse(p + 2);
		look();
		apb(1, ADDR_IRQ_EN, 0);
		start(CK_PIN_RISE, 8'hC0, 5, 0);
		pulse(1025);
		look();
		chk("irq masked", 0, irq);
		$display("end of period test");
		for (int f = 0; f < 2; f++) begin
			start(CK_SYS, 8'(8'h88 | (f << 4)), 0, 0);
			chk("pwm level", f, pin);
		end
		$display("end of pwm level test");
		for (int f = 1; f < 3; f++) begin
			start(CK_PIN_RISE, 8'((f << 4) | ((2 - f) << 3) | 1), 2, 0);
			chk("initial level", 2 - f, pin);
			pulse(3);
			chk("match level", f - 1, pin);
		end
		start(CK_PIN_RISE, 8'hA8, 2, 4);
		repeat (6) begin
			pulse(1);
			chk("pwm duty", cnt < a, pin);
		end
		look();
		start(CK_PIN_RISE, 8'hB8, 3, 0);
		chk("pulse start", 1, pin);
		on = 0;
		pulse(6);
		cnt = a;
		stat = 1;
		look();
		chk("pulse end", 0, pin);
		apb(0, ADDR_CTRL0, 0);
		chk("run cleared", {25'h0, CK_PIN_RISE, 4'h0}, rdat);
		$display("end of output mode test");
		timed(CK_SYS4, 1 + ($random(seed) & 7), 4);
		timed(CK_H16, 3, 16);
		timed(CK_H64, 2, 64);
		timed(CK_SUB1, 2 + ($random(seed) & 7), 0);
		$display("end of clock select test");
		end_sim();
	end
endmodule
`default_nettype wire
